// ### common/pspc_pkg.sv
// constants and types for the print start position controller
package pspc_pkg;
	// clock and tick timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 2500000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// safe zone and start qualification, in transitions; PRELOAD_SETS counts dot sets
	localparam logic [16:0] ZONE_MARGIN = 17'h00003;
	localparam logic [16:0] FAR_SKIP_LIMIT = 17'h000FF;
	localparam logic [16:0] FAR_START_LIMIT = 17'h00022;
	localparam logic [16:0] SPEED_VALID_MAX = 17'h0007F;
	localparam logic [7:0] SPEED_MARGIN = 8'h02;
	localparam logic [2:0] PRELOAD_SETS = 3'h4;
	// dot rate limiting: half-dots allowed per tick is 2 * 2200 * 2.5 ms
	localparam int DOT_RATE_MAX = 2200;
	// split so the product stays inside a 32-bit int
	localparam logic [15:0] HALF_DOTS_PER_TICK = 16'(2 * DOT_RATE_MAX * (TICK_PERIOD_NS / 1000) / 1000000);
	localparam logic [15:0] BUDGET_MAX = 16'h0B00;
	localparam int BUDGET_SHIFT = 4;
	// flight time: about 400 us, 0.16 tick; factor 41/256
	localparam int FLIGHT_TIME_US = 400;
	localparam logic [7:0] FLIGHT_NUM = 8'h29;
	localparam int FLIGHT_SHIFT = 8;
	// servo
	localparam int SERVO_SHIFT = 2;
	localparam logic [7:0] SLEW_LIMIT = 8'h7F;
	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CELL_LEAD = 8'h04;
	localparam logic [7:0] REG_CELL_GAP = 8'h08;
	localparam logic [7:0] REG_FONT_LIMIT = 8'h0C;
	localparam logic [7:0] REG_TARGET = 8'h10;
	localparam logic [7:0] REG_DOT_DATA = 8'h14;
	localparam logic [7:0] REG_COMP_BIAS = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_POSITION = 8'h20;
	localparam logic [7:0] REG_LIMIT = 8'h24;
	// reset values
	localparam logic [7:0] FONT_LIMIT_RESET = 8'h40;
	localparam logic [15:0] BUDGET_RESET = 16'h0B00;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_PREP = 5'h02,
		ST_APPROACH = 5'h04,
		ST_DONE = 5'h08,
		ST_ABORT = 5'h10
	} pspc_state_type;
endpackage

// ### logic/pspc_host.sv
// host controller: print start qualification, dot feed, servo and dot rate limit
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module pspc_host #(
	parameter int TICK_CYC = pspc_pkg::TICK_CYCLES,
	parameter int POS_W = 16
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// device pins in
	input wire logic [POS_W-1:0] POS_COUNT,
	input wire logic DOT_REQ,
	input wire logic PAPER_OUT,
	input wire logic COVER_OPEN,
	// device pins out
	output logic PRINT_START,
	output logic TRANS_ADD,
	output logic TRANS_SUB,
	output logic [8:0] DOT_DATA,
	output logic DOT_PUSH,
	output logic DOT_IRQ_EN,
	output logic [7:0] SPEED_CMD,
	output logic TICK_CLEAR
);
	typedef struct packed {
		pspc_pkg::pspc_state_type st;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic reverse;
		logic vmotion;
		logic [15:0] cell_lead;
		logic [15:0] cell_gap;
		logic [7:0] font_lim;
		logic [15:0] target;
		logic [3:0] comp_bias;
		logic [17:0] tick_cnt;
		logic [15:0] prev_pos;
		logic [15:0] speed;
		logic [7:0] dots_tick;
		logic [15:0] budget;
		logic [7:0] comp_applied;
		logic [2:0] loaded;
		logic started;
		logic aborted;
		logic print_start;
		logic trans_add;
		logic trans_sub;
		logic [8:0] dot_data;
		logic dot_push;
		logic dot_irq_en;
		logic [7:0] speed_cmd;
		logic tick_clear;
	} pspc_regs_type;
	pspc_regs_type r;
	pspc_regs_type next_r;
	logic [POS_W-1:0] pos_sync;
	logic [2:0] flags_sync;
	pspc_sync #(.WIDTH(POS_W)) u_pos_sync (.clk(MCLK), .rst(RST), .d(POS_COUNT), .q(pos_sync));
	pspc_sync #(.WIDTH(3)) u_flag_sync (.clk(MCLK), .rst(RST), .d({DOT_REQ, PAPER_OUT, COVER_OPEN}), .q(flags_sync));
	// qualification terms, mirrored by direction
	logic signed [16:0] pos_s;
	logic signed [16:0] spd_now;
	logic signed [16:0] spd_dir;
	logic signed [16:0] proj;
	logic signed [16:0] zone_near;
	logic signed [16:0] zone_far;
	logic signed [16:0] d_far;
	logic signed [16:0] d_near;
	logic [7:0] therm_lim;
	logic [7:0] eff_lim;
	logic tick_hit;
	logic fault;
	logic qual_tick;
	logic apb_setup;
	logic apb_wr;
	always_comb begin
		pos_s = 17'(signed'(pos_sync));
		spd_now = 17'(signed'(16'(pos_sync - r.prev_pos)));
		spd_dir = r.reverse ? -spd_now : spd_now;
		proj = pos_s + spd_now;
		zone_near = r.reverse ? 17'(signed'(r.cell_lead)) - signed'(pspc_pkg::ZONE_MARGIN)
			: 17'(signed'(r.cell_lead)) + signed'(pspc_pkg::ZONE_MARGIN);
		zone_far = r.reverse ? 17'(signed'(r.cell_gap)) + signed'(pspc_pkg::ZONE_MARGIN)
			: 17'(signed'(r.cell_gap)) - signed'(pspc_pkg::ZONE_MARGIN);
		d_far = r.reverse ? proj - zone_far : zone_far - proj;
		d_near = r.reverse ? zone_near - proj : proj - zone_near;
		therm_lim = 8'(r.budget >> pspc_pkg::BUDGET_SHIFT);
		eff_lim = (therm_lim < r.font_lim) ? therm_lim : r.font_lim;
		tick_hit = (r.tick_cnt == 18'(TICK_CYC - 1));
		fault = r.vmotion | flags_sync[1] | flags_sync[0];
		qual_tick = tick_hit && (r.st == pspc_pkg::ST_APPROACH);
		apb_setup = PSEL && !PENABLE && !r.pready;
		apb_wr = PSEL && PENABLE && r.pready && PWRITE && !r.pslverr;
	end
	always_comb begin
		logic signed [16:0] err;
		logic signed [16:0] cmd;
		logic signed [16:0] lim;
		logic [15:0] aspd;
		logic signed [16:0] want;
		logic signed [16:0] bud;
		logic [15:0] dmax;
		err = '0;
		cmd = '0;
		lim = '0;
		aspd = '0;
		want = '0;
		bud = '0;
		dmax = '0;
		next_r = r;
		next_r.print_start = 1'b0;
		next_r.trans_add = 1'b0;
		next_r.trans_sub = 1'b0;
		next_r.dot_push = 1'b0;
		next_r.tick_clear = 1'b0;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		// apb: setup cycle latches answer, access cycle completes
		if (apb_setup) begin
			next_r.pready = 1'b1;
			next_r.prdata = '0;
			unique case (PADDR)
				pspc_pkg::REG_CTRL: next_r.prdata = {28'h0000000, r.dot_irq_en, r.vmotion, r.reverse,
					r.st == pspc_pkg::ST_APPROACH || r.st == pspc_pkg::ST_PREP};
				pspc_pkg::REG_CELL_LEAD: next_r.prdata = {16'h0000, r.cell_lead};
				pspc_pkg::REG_CELL_GAP: next_r.prdata = {16'h0000, r.cell_gap};
				pspc_pkg::REG_FONT_LIMIT: next_r.prdata = {24'h000000, r.font_lim};
				pspc_pkg::REG_TARGET: next_r.prdata = {16'h0000, r.target};
				pspc_pkg::REG_DOT_DATA: next_r.prdata = {23'h000000, r.dot_data};
				pspc_pkg::REG_COMP_BIAS: next_r.prdata = {28'h0000000, r.comp_bias};
				pspc_pkg::REG_STATUS: next_r.prdata = {22'h000000, r.loaded, flags_sync[2], r.aborted, r.started,
					r.st == pspc_pkg::ST_DONE, r.st == pspc_pkg::ST_ABORT, r.st == pspc_pkg::ST_APPROACH,
					r.st == pspc_pkg::ST_PREP};
				pspc_pkg::REG_POSITION: next_r.prdata = {r.speed, pos_sync};
				pspc_pkg::REG_LIMIT: next_r.prdata = {r.budget, 8'h00, eff_lim};
				default: next_r.pslverr = 1'b1;
			endcase
		end
		if (apb_wr) begin
			unique case (PADDR)
				pspc_pkg::REG_CTRL: begin
					next_r.reverse = PWDATA[1];
					next_r.vmotion = PWDATA[2];
					if (PWDATA[0] && r.st != pspc_pkg::ST_APPROACH && r.st != pspc_pkg::ST_PREP) begin
						next_r.st = pspc_pkg::ST_PREP;
						next_r.loaded = '0;
						next_r.dot_irq_en = 1'b0;
					end else if (!PWDATA[0] && r.st != pspc_pkg::ST_DONE) begin
						next_r.st = pspc_pkg::ST_IDLE;
						next_r.dot_irq_en = 1'b0;
					end
				end
				pspc_pkg::REG_CELL_LEAD: next_r.cell_lead = PWDATA[15:0];
				pspc_pkg::REG_CELL_GAP: next_r.cell_gap = PWDATA[15:0];
				pspc_pkg::REG_FONT_LIMIT: next_r.font_lim = PWDATA[7:0];
				pspc_pkg::REG_TARGET: next_r.target = PWDATA[15:0];
				pspc_pkg::REG_DOT_DATA: begin
					next_r.dot_data = PWDATA[8:0];
					next_r.dot_push = 1'b1;
					if (r.dots_tick != 8'hFF) begin
						next_r.dots_tick = r.dots_tick + 8'h01;
					end
					if (r.st == pspc_pkg::ST_PREP) begin
						next_r.loaded = r.loaded + 3'h1;
						if (r.loaded == pspc_pkg::PRELOAD_SETS - 3'h1) begin
							next_r.dot_irq_en = 1'b1;
							next_r.st = pspc_pkg::ST_APPROACH;
						end
					end
				end
				pspc_pkg::REG_COMP_BIAS: next_r.comp_bias = PWDATA[3:0];
				pspc_pkg::REG_STATUS: begin
					next_r.started = r.started & ~PWDATA[0];
					next_r.aborted = r.aborted & ~PWDATA[1];
				end
				default: ;
			endcase
		end
		// tick: speed, servo, dot budget, flight compensation, qualification
		next_r.tick_cnt = tick_hit ? '0 : r.tick_cnt + 18'h00001;
		if (tick_hit) begin
			next_r.tick_clear = 1'b1;
			next_r.prev_pos = pos_sync;
			next_r.speed = spd_now[15:0];
			bud = 17'(signed'({1'b0, r.budget})) + 17'(signed'({1'b0, pspc_pkg::HALF_DOTS_PER_TICK}))
				- 17'(signed'({8'h00, r.dots_tick, 1'b0}));
			next_r.budget = (bud < 0) ? 16'h0000 : (bud > 17'(pspc_pkg::BUDGET_MAX)) ? pspc_pkg::BUDGET_MAX : bud[15:0];
			next_r.dots_tick = (apb_wr && PADDR == pspc_pkg::REG_DOT_DATA) ? 8'h01 : 8'h00;
			err = 17'(signed'(r.target)) - pos_s;
			lim = (r.st == pspc_pkg::ST_APPROACH || r.st == pspc_pkg::ST_DONE) ? 17'(eff_lim)
				: 17'(pspc_pkg::SLEW_LIMIT);
			cmd = err >>> pspc_pkg::SERVO_SHIFT;
			if (cmd > lim) cmd = lim;
			if (cmd < -lim) cmd = -lim;
			next_r.speed_cmd = fault ? 8'h00 : cmd[7:0];
			aspd = spd_now[16] ? 16'(-spd_now) : spd_now[15:0];
			want = 17'(({8'h00, aspd[7:0]} * {8'h00, pspc_pkg::FLIGHT_NUM}) >> pspc_pkg::FLIGHT_SHIFT)
				+ 17'(signed'(r.comp_bias));
			if (r.reverse) want = -want;
			if (want > 17'(signed'(r.comp_applied))) begin
				next_r.trans_add = 1'b1;
				next_r.comp_applied = r.comp_applied + 8'h01;
			end else if (want < 17'(signed'(r.comp_applied))) begin
				next_r.trans_sub = 1'b1;
				next_r.comp_applied = r.comp_applied - 8'h01;
			end
		end
		if (qual_tick) begin
			dmax = {8'h00, eff_lim + pspc_pkg::SPEED_MARGIN};
			if (fault || spd_dir < 0 || d_far < 0) begin
				next_r.st = pspc_pkg::ST_ABORT;
				next_r.dot_irq_en = 1'b0;
				next_r.aborted = 1'b1;
			end else if (d_far > 17'(pspc_pkg::FAR_SKIP_LIMIT)) begin
				next_r.st = pspc_pkg::ST_APPROACH;
			end else if (spd_dir < 17'(dmax) && d_far < 17'(pspc_pkg::FAR_START_LIMIT)
				&& spd_dir > 0 && spd_dir <= 17'(pspc_pkg::SPEED_VALID_MAX) && d_far > spd_dir) begin
				if (d_near > 0) begin
					next_r.print_start = 1'b1;
					next_r.st = pspc_pkg::ST_DONE;
					next_r.started = 1'b1;
				end else begin
					next_r.st = pspc_pkg::ST_ABORT;
					next_r.dot_irq_en = 1'b0;
					next_r.aborted = 1'b1;
				end
			end
		end
	end
	always_ff @(posedge MCLK) begin
		if (RST) begin
			r <= '0;
			r.st <= pspc_pkg::ST_IDLE;
			r.font_lim <= pspc_pkg::FONT_LIMIT_RESET;
			r.budget <= pspc_pkg::BUDGET_RESET;
		end else begin
			r <= next_r;
		end
	end
	assign PRDATA = r.prdata;
	assign PREADY = r.pready;
	assign PSLVERR = r.pslverr;
	assign PRINT_START = r.print_start;
	assign TRANS_ADD = r.trans_add;
	assign TRANS_SUB = r.trans_sub;
	assign DOT_DATA = r.dot_data;
	assign DOT_PUSH = r.dot_push;
	assign DOT_IRQ_EN = r.dot_irq_en;
	assign SPEED_CMD = r.speed_cmd;
	assign TICK_CLEAR = r.tick_clear;
	// checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	a_irq_after_four: assert property ($rose(DOT_IRQ_EN) |-> $past(r.loaded) == 3'h3)
		else $error("dot interrupt enabled before four dot sets");
	a_fault_aborts: assert property (qual_tick && fault |=> r.st == pspc_pkg::ST_ABORT && !PRINT_START)
		else $error("fault did not abort start");
	a_dir_start: assert property (PRINT_START |-> $past(spd_dir) > 0)
		else $error("start issued while moving the wrong way");
	a_overshoot_abort: assert property (qual_tick && !fault && spd_dir >= 0 && d_far < 0
		|=> r.st == pspc_pkg::ST_ABORT)
		else $error("overshoot did not abort");
	a_far_skip: assert property (qual_tick && !fault && spd_dir >= 0 && d_far > 17'sd255
		|=> r.st == pspc_pkg::ST_APPROACH && !PRINT_START)
		else $error("far projection did not wait");
	a_start_window: assert property (PRINT_START |-> $past(d_far) < 17'sd34 && $past(d_near) > 0)
		else $error("start outside safe window");
	a_start_on_tick: assert property (PRINT_START |-> $past(qual_tick) ##1 !PRINT_START[*3])
		else $error("start not tied to an approach tick");
	a_trim_single: assert property (TRANS_ADD || TRANS_SUB |-> !(TRANS_ADD && TRANS_SUB) && $past(tick_hit))
		else $error("trim pulse malformed");
	a_limit_lower: assert property (eff_lim <= r.font_lim && eff_lim <= therm_lim)
		else $error("speed limit not the lower value");
	a_tick_clear: assert property (TICK_CLEAR |=> !TICK_CLEAR && r.tick_cnt == 18'h00001)
		else $error("tick clear malformed");
	a_apb_answer: assert property (apb_setup |=> PREADY ##1 !PREADY)
		else $error("apb answer not one cycle after setup");
	c_start: cover property (PRINT_START);
	c_abort: cover property ($rose(r.aborted));
	c_trim: cover property (TRANS_ADD ##[1:1000] TRANS_SUB);
	c_reverse_start: cover property (r.reverse && PRINT_START);
endmodule // pspc_host

// ### logic/pspc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pspc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} pspc_sync_type;
	pspc_sync_type r;
	pspc_sync_type next_r;
	always_comb begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign q = r.s2;
endmodule // pspc_sync

// ### tb/pspc_dev_model.sv
// behavioural model of the printer controller chip at the far side
`timescale 1ns/1ps
module pspc_dev_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// encoder channels and next gap boundary
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic [15:0] gap,
	// commands from the controller
	input wire logic print_start,
	input wire logic trans_add,
	input wire logic trans_sub,
	input wire logic dot_push,
	// status towards the controller
	output logic [15:0] pos,
	output logic dot_req,
	output logic signed [7:0] trim,
	output logic printing
);
	logic pa;
	logic pb;
	logic pend;
	logic moved;
	logic [15:0] np;
	logic [2:0] fill;
	assign moved = (enc_a != pa) ^ (enc_b != pb);
	assign np = (pa ^ enc_b) ? pos + 16'h0001 : pos - 16'h0001;
	assign dot_req = printing && fill <= 3'h2;
	always_ff @(posedge clk) begin
		if (rst) begin
			pa <= 1'b0;
			pb <= 1'b0;
			pend <= 1'b0;
			printing <= 1'b0;
			pos <= 16'h0000;
			trim <= 8'sh00;
			fill <= 3'h0;
		end else begin
			pa <= enc_a;
			pb <= enc_b;
			if (trans_add)
				trim <= trim + 8'sh01;
			else if (trans_sub)
				trim <= trim - 8'sh01;
			if (dot_push && fill != 3'h7)
				fill <= fill + 3'h1;
			// counting goes on while a start command arrives
			if (moved) begin
				pos <= np;
				if (pend && ((pos < gap) != (np < gap))) begin
					pend <= 1'b0;
					printing <= 1'b1;
				end
				if (printing && fill != 3'h0 && !dot_push)
					fill <= fill - 3'h1;
			end
			if (print_start) begin
				pend <= 1'b1;
				printing <= 1'b0;
			end
		end
	end
endmodule // pspc_dev_model

// ### tb/testbench.sv
// self-checking bench for the print start position controller
`timescale 1ns/1ps
module testbench;
	logic MCLK, RST, psel, penable, pwrite, cover_open, paper, ea, eb, pready, pslverr, e;
	logic print_start, t_add, t_sub, dot_push, irq_en, tclr, dot_req, printing;
	logic [7:0] paddr, speed;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] pos, gap_pos, want_pos;
	logic [8:0] dot_data;
	logic [1:0] ph;
	logic signed [7:0] trim;
	int fails, comparisons, starts;
	pspc_host #(.TICK_CYC(200), .POS_W(16)) uut (.MCLK(MCLK), .RST(RST), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.POS_COUNT(pos), .DOT_REQ(dot_req), .PAPER_OUT(paper), .COVER_OPEN(cover_open), .PRINT_START(print_start),
		.TRANS_ADD(t_add), .TRANS_SUB(t_sub), .DOT_DATA(dot_data), .DOT_PUSH(dot_push), .DOT_IRQ_EN(irq_en),
		.SPEED_CMD(speed), .TICK_CLEAR(tclr));
	pspc_dev_model dev (.clk(MCLK), .rst(RST), .enc_a(ea), .enc_b(eb), .gap(gap_pos), .print_start(print_start),
		.trans_add(t_add), .trans_sub(t_sub), .dot_push(dot_push), .pos(pos), .dot_req(dot_req), .trim(trim),
		.printing(printing));
	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	always @(posedge MCLK) if (print_start === 1'b1) starts <= starts + 1;
	task automatic final_report;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge MCLK) penable <= 1'b1;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			final_report();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge MCLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h00000000);
	endtask
	task automatic wait_tick;
		int n;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (tclr !== 1'b1 && n < 250);
		if (n >= 250) begin
			fails++;
			final_report();
		end
	endtask
	task automatic move(input int n);
		repeat ((n < 0) ? -n : n) begin
			ph = (n < 0) ? ph - 2'h1 : ph + 2'h1;
			want_pos = (n < 0) ? want_pos - 16'h0001 : want_pos + 16'h0001;
			ea <= ph[1];
			eb <= ph[1] ^ ph[0];
			repeat (2) @(posedge MCLK);
		end
	endtask
	task automatic attempt(input logic [31:0] ctrl, input logic [31:0] lead, input logic [31:0] gap, input int stp);
		int n;
		gap_pos <= gap[15:0];
		repeat (2) wait_tick();
		wr(pspc_pkg::REG_STATUS, 32'h00000003);
		wr(pspc_pkg::REG_CELL_LEAD, lead);
		wr(pspc_pkg::REG_CELL_GAP, gap);
		wr(pspc_pkg::REG_CTRL, ctrl);
		repeat (4) wr(pspc_pkg::REG_DOT_DATA, 32'h000001A5);
		chk(irq_en, 1);
		n = 0;
		q = 32'h00000000;
		while (n < 12 && q[5:4] === 2'b00) begin
			wait_tick();
			move(stp);
			rd(pspc_pkg::REG_STATUS);
			n++;
		end
	endtask
	task automatic sc_reset;
		rd(pspc_pkg::REG_CTRL);
		chk(q, 32'h00000000);
		rd(pspc_pkg::REG_FONT_LIMIT);
		chk(q, 32'h00000040);
		rd(pspc_pkg::REG_LIMIT);
		chk(q, 32'h0B000040);
		rd(8'h30);
		chk({31'h0, e}, 1);
		chk(q, 0);
	endtask
	task automatic sc_cover;
		int s0;
		s0 = starts;
		cover_open <= 1'b1;
		attempt(32'h1, 32'h100, 32'h180, 0);
		chk(q[5:4], 2'h2);
		chk(starts - s0, 0);
		chk(speed, 32'h00000000);
		cover_open <= 1'b0;
	endtask
	task automatic sc_forward;
		int s0;
		move(336);
		// let trim settle back to zero and the position pass the synchroniser
		repeat (6) wait_tick();
		rd(pspc_pkg::REG_POSITION);
		chk(q[15:0], want_pos);
		s0 = starts;
		attempt(32'h1, 32'h100, 32'h180, 8);
		chk(q[5:4], 2'h1);
		chk(starts - s0, 1);
		chk(trim, 1);
		chk(printing, 0);
		move(48);
		chk(printing, 1);
		wait_tick();
		chk(speed, 32'h000000C0);
	endtask
	task automatic sc_reverse;
		int s0;
		move(704 - int'(want_pos));
		repeat (6) wait_tick();
		s0 = starts;
		attempt(32'h3, 32'h300, 32'h280, -8);
		chk(q[5:4], 2'h1);
		chk(starts - s0, 1);
		chk(trim, 32'hFFFFFFFF);
		chk(printing, 0);
		move(-72);
		chk(printing, 1);
		repeat (4) @(posedge MCLK);
		rd(pspc_pkg::REG_POSITION);
		chk(q[15:0], want_pos);
	endtask
	task automatic sc_overshoot;
		int s0;
		s0 = starts;
		attempt(32'h1, 32'h100, 32'h180, 0);
		chk(q[5:4], 2'h2);
		chk(starts - s0, 0);
	endtask
	initial begin
		{RST, psel, penable, pwrite, cover_open, paper, ea, eb} = 8'h80;
		{paddr, pwdata, gap_pos, want_pos, ph} = '0;
		{fails, comparisons, starts} = '0;
		repeat (3) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		sc_reset();
		sc_cover();
		sc_forward();
		sc_reverse();
		sc_overshoot();
		final_report();
	end
endmodule // testbench
